// ### hw/pom_consts.vh
// constants for the pin override monitor
`ifndef POM_CONSTS_VH
`define POM_CONSTS_VH
`define POM_ADDR_W 8
`define POM_OFS_SRC0 8'h50
`define POM_OFS_SRC1 8'h51
`define POM_OFS_SRC2 8'h52
`define POM_OFS_SRC3 8'h53
`define POM_OFS_MON 8'h54
`define POM_OFS_EN 8'h55
`define POM_OFS_STS 8'h56
`define POM_OFS_IFLG 8'h57
`define POM_OFS_IEN 8'h58
`define POM_OFS_MASK0_LO 8'h60
`define POM_OFS_OUT_LO 8'h68
`define POM_OFS_OUT_HI 8'h69
`define POM_OFS_DIR_LO 8'h6A
`define POM_OFS_DIR_HI 8'h6B
`define POM_SRC_COMP1 5'h10
`define POM_SRC_BUSDET 5'h11
`define POM_THR_SAFE0 3'h0
`define POM_THR_BUS0 3'h1
`define POM_THR_BUS1 3'h2
`define POM_THR_BUS2 3'h3
`define POM_SRC_RESET 8'h00
`endif

// ### hw/pom_function.v
// one override function: source select, match and active flag
`timescale 1ns/1ps
`default_nettype none
`include "pom_consts.vh"
module pom_function (
  input wire sys_clk,
  input wire resetn,
  input wire [7:0] sourceSelect,
  input wire monitorLevel,
  input wire functionEnable,
  input wire [15:0] pinLevel,
  input wire comparatorOne,
  input wire [4:0] busMatch,
  output reg active,
  output wire matchPulse
);
  reg watched;
  reg valid;
  wire [2:0] thrSel = sourceSelect[7:5];
  wire [4:0] srcSel = sourceSelect[4:0];
  always @* begin
    valid = 1'b1;
    watched = 1'b0;
    if (srcSel[4] == 1'b0) begin
      watched = pinLevel[srcSel[3:0]];
    end else if (srcSel == `POM_SRC_COMP1) begin
      watched = comparatorOne;
    end else if (srcSel == `POM_SRC_BUSDET) begin
      case (thrSel)
        `POM_THR_SAFE0: watched = busMatch[0];
        `POM_THR_BUS0: watched = busMatch[1];
        `POM_THR_BUS1: watched = busMatch[2];
        `POM_THR_BUS2: watched = busMatch[3];
        default: watched = busMatch[4];
      endcase
    end else begin
      // reserved codes never trigger
      valid = 1'b0;
    end
  end
  // comparator inputs are high when above threshold, so level compare covers both cases
  wire match = functionEnable & valid & (watched == monitorLevel);
  assign matchPulse = match & ~active;
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      active <= 1'b0;
    end else if (!functionEnable) begin
      active <= 1'b0;
    end else if (match) begin
      active <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// ### hw/pin_override_monitor.v
// pin override monitor: registers, four functions, pin takeover and interrupt
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "pom_consts.vh"
module pom_pin_override_monitor (
  input wire sys_clk,
  input wire resetn,
  input wire [7:0] regAddr,
  input wire [7:0] regWdata,
  input wire regWrite,
  input wire regRead,
  output reg [7:0] regRdata,
  input wire [15:0] generalPinIn,
  input wire overcurrentComparatorOne,
  input wire overcurrentComparatorTwo,
  input wire safeZeroLevelMatch,
  input wire busThreshold0Match,
  input wire busThreshold1Match,
  input wire busThreshold2Match,
  input wire busThreshold3Match,
  input wire [15:0] normalPinOut,
  input wire [15:0] normalPinOutEnN,
  output reg [15:0] generalPinOut,
  output reg [15:0] generalPinOutEnN,
  output wire [3:0] overrideActive,
  output wire overrideIrq
);
  // two-flop synchronisers for every asynchronous source
  reg [22:0] syncA;
  reg [22:0] syncB;
  wire [22:0] rawIn = {busThreshold3Match, busThreshold2Match, busThreshold1Match, busThreshold0Match,
    safeZeroLevelMatch, overcurrentComparatorTwo, overcurrentComparatorOne, generalPinIn};
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      syncA <= 23'h000000;
      syncB <= 23'h000000;
    end else begin
      syncA <= rawIn;
      syncB <= syncA;
    end
  end
  wire [15:0] pinRaw = syncB[15:0];
  wire comp1 = syncB[16];
  wire comp2 = syncB[17];
  wire [4:0] busMatch = syncB[22:18];
  // code 2 watches pin 2 or comparator two; they share the ball, so combine
  wire [15:0] pinLevel = {pinRaw[15:3], pinRaw[2] | comp2, pinRaw[1:0]};

  reg [7:0] sourceSelect [0:3];
  reg [3:0] monitorLevel;
  reg [3:0] overrideFunctionEnable;
  reg [3:0] overrideInterruptFlag;
  reg [3:0] overrideInterruptEnable;
  reg [15:0] overridePinMask [0:3];
  reg [15:0] overrideOutputValue;
  reg [15:0] overrideDirection;
  wire [3:0] matchPulse;

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : fn
      pom_function uFunc (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .sourceSelect(sourceSelect[g]),
        .monitorLevel(monitorLevel[g]),
        .functionEnable(overrideFunctionEnable[g]),
        .pinLevel(pinLevel),
        .comparatorOne(comp1),
        .busMatch(busMatch),
        .active(overrideActive[g]),
        .matchPulse(matchPulse[g])
      );
    end
  endgenerate

  // compare against the base offsets bit for bit so no widths are mixed
  wire [7:0] srcBase = `POM_OFS_SRC0;
  wire [7:0] maskBase = `POM_OFS_MASK0_LO;
  wire inSrc = (regAddr[7:2] == srcBase[7:2]);
  wire inMask = (regAddr[7:3] == maskBase[7:3]);
  wire wrSrc = regWrite && inSrc;
  wire wrMask = regWrite && inMask;
  integer i;
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      for (i = 0; i < 4; i = i + 1) begin
        sourceSelect[i] <= `POM_SRC_RESET;
        overridePinMask[i] <= 16'h0000;
      end
      monitorLevel <= 4'h0;
      overrideFunctionEnable <= 4'h0;
      overrideInterruptEnable <= 4'h0;
      overrideOutputValue <= 16'h0000;
      overrideDirection <= 16'h0000;
    end else if (regWrite) begin
      if (wrSrc) begin
        sourceSelect[regAddr[1:0]] <= regWdata;
      end
      if (wrMask) begin
        if (regAddr[0]) begin
          overridePinMask[regAddr[2:1]][15:8] <= regWdata;
        end else begin
          overridePinMask[regAddr[2:1]][7:0] <= regWdata;
        end
      end
      case (regAddr)
        `POM_OFS_MON: monitorLevel <= regWdata[3:0];
        `POM_OFS_EN: overrideFunctionEnable <= regWdata[3:0];
        `POM_OFS_IEN: overrideInterruptEnable <= regWdata[3:0];
        `POM_OFS_OUT_LO: overrideOutputValue[7:0] <= regWdata;
        `POM_OFS_OUT_HI: overrideOutputValue[15:8] <= regWdata;
        `POM_OFS_DIR_LO: overrideDirection[7:0] <= regWdata;
        `POM_OFS_DIR_HI: overrideDirection[15:8] <= regWdata;
        default: begin
        end
      endcase
    end
  end

  // flags: a new match wins over a write-one clear in the same cycle
  wire [3:0] flagClear = (regWrite && regAddr == `POM_OFS_IFLG) ? regWdata[3:0] : 4'h0;
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      overrideInterruptFlag <= 4'h0;
    end else begin
      overrideInterruptFlag <= (overrideInterruptFlag & ~flagClear) | matchPulse;
    end
  end
  assign overrideIrq = |(overrideInterruptFlag & overrideInterruptEnable);

  // pin takeover; overlapping masks share the one value and direction pair
  reg [15:0] next_pinOut;
  reg [15:0] next_pinOutEnN;
  reg [15:0] claimed;
  integer f;
  always @* begin
    claimed = 16'h0000;
    for (f = 0; f < 4; f = f + 1) begin
      if (overrideActive[f]) begin
        claimed = claimed | overridePinMask[f];
      end
    end
    next_pinOut = (normalPinOut & ~claimed) | (overrideOutputValue & claimed);
    next_pinOutEnN = (normalPinOutEnN & ~claimed) | (~overrideDirection & claimed);
  end
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      generalPinOut <= 16'h0000;
      generalPinOutEnN <= 16'hFFFF;
    end else begin
      generalPinOut <= next_pinOut;
      generalPinOutEnN <= next_pinOutEnN;
    end
  end

  // read data one cycle after the strobe; unmapped reads zero
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      regRdata <= 8'h00;
    end else if (regRead) begin
      if (inSrc) begin
        regRdata <= sourceSelect[regAddr[1:0]];
      end else if (inMask) begin
        regRdata <= regAddr[0] ? overridePinMask[regAddr[2:1]][15:8] : overridePinMask[regAddr[2:1]][7:0];
      end else begin
        case (regAddr)
          `POM_OFS_MON: regRdata <= {4'h0, monitorLevel};
          `POM_OFS_EN: regRdata <= {4'h0, overrideFunctionEnable};
          `POM_OFS_STS: regRdata <= {4'h0, overrideActive};
          `POM_OFS_IFLG: regRdata <= {4'h0, overrideInterruptFlag};
          `POM_OFS_IEN: regRdata <= {4'h0, overrideInterruptEnable};
          `POM_OFS_OUT_LO: regRdata <= overrideOutputValue[7:0];
          `POM_OFS_OUT_HI: regRdata <= overrideOutputValue[15:8];
          `POM_OFS_DIR_LO: regRdata <= overrideDirection[7:0];
          `POM_OFS_DIR_HI: regRdata <= overrideDirection[15:8];
          default: regRdata <= 8'h00;
        endcase
      end
    end else begin
      regRdata <= 8'h00;
    end
  end
endmodule
`default_nettype wire

// ### bench/pom_monitor_sva.sv
// port assertions for the pin override monitor
`timescale 1ns/1ps
`default_nettype none
module pom_monitor_sva (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regRdata,
  input wire logic [15:0] normalPinOut,
  input wire logic [15:0] normalPinOutEnN,
  input wire logic [15:0] generalPinOut,
  input wire logic [15:0] generalPinOutEnN,
  input wire logic [3:0] overrideActive,
  input wire logic overrideIrq
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  chk_rsvd_zero: assert property (
    $past(regRead) && $past(regAddr) inside {[8'h54:8'h58]} |-> regRdata[7:4] == 4'h0)
    else $error("reserved bits set");
  chk_rdata_idle: assert property (
    !$past(regRead) |-> regRdata == 8'h00) else $error("read data outside slot");
  chk_status_read: assert property (
    $past(regRead) && $past(regAddr) == 8'h56 |-> regRdata == {4'h0, $past(overrideActive)})
    else $error("status read differs");
  chk_irq_rise: assert property (
    $rose(overrideIrq) |-> ($past(regWrite) && $past(regAddr) == 8'h58) || (overrideActive & ~$past(overrideActive)) != 4'h0)
    else $error("irq rose without cause");
  chk_irq_fall: assert property (
    $fell(overrideIrq) |-> $past(regWrite) && $past(regAddr) inside {8'h57, 8'h58}) else $error("irq fell without write");
  chk_active_hold: assert property (
    ($past(overrideActive) & ~overrideActive) != 4'h0 |-> $past(regWrite, 2) && $past(regAddr, 2) == 8'h55)
    else $error("active dropped");
  chk_enable_clear: assert property (
    $past(regWrite) && $past(regAddr) == 8'h55 |-> ##1 (overrideActive & ~$past(regWdata[3:0], 2)) == 4'h0)
    else $error("active without enable");
  chk_pin_follow: assert property (
    $past(resetn) && $past(overrideActive) == 4'h0 |->
    generalPinOut == $past(normalPinOut) && generalPinOutEnN == $past(normalPinOutEnN))
    else $error("pins not normal");
  cover property ($rose(overrideIrq));
  cover property ($fell(overrideIrq));
  cover property ($fell(|overrideActive));
endmodule
bind pom_pin_override_monitor pom_monitor_sva u_pom_monitor_sva (.sys_clk, .resetn, .regAddr, .regWdata, .regWrite,
  .regRead, .regRdata, .normalPinOut, .normalPinOutEnN, .generalPinOut, .generalPinOutEnN, .overrideActive, .overrideIrq);
`default_nettype wire

// ### bench/tb_pin_override_monitor.sv
// self-checking bench for the pin override monitor
`timescale 1ns/1ps
`default_nettype none
module tb_pin_override_monitor;
  logic sys_clk, resetn, regWrite, regRead;
  logic [7:0] regAddr, regWdata;
  logic [15:0] pinIn, normOut, normEnN;
  logic [6:0] cmpIn;
  wire [7:0] regRdata;
  wire [15:0] pinOut, pinEnN;
  wire [3:0] active;
  wire irq;
  int mismatches, cmp_count, cycles;
  pom_pin_override_monitor u_pom_pin_override_monitor (.sys_clk, .resetn, .regAddr, .regWdata, .regWrite, .regRead,
    .regRdata, .generalPinIn(pinIn), .overcurrentComparatorOne(cmpIn[0]), .overcurrentComparatorTwo(cmpIn[6]),
    .safeZeroLevelMatch(cmpIn[1]), .busThreshold0Match(cmpIn[2]), .busThreshold1Match(cmpIn[3]),
    .busThreshold2Match(cmpIn[4]), .busThreshold3Match(cmpIn[5]), .normalPinOut(normOut), .normalPinOutEnN(normEnN),
    .generalPinOut(pinOut), .generalPinOutEnN(pinEnN), .overrideActive(active), .overrideIrq(irq));
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // generous ceiling, the run needs well under a thousand cycles
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      summarize();
    end
  end
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge sys_clk);
    regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
    @(posedge sys_clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge sys_clk);
    regRead <= 1'b0;
    #1 chk(what, exp, regRdata);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic t_reset;
    for (int a = 8'h50; a <= 8'h58; a++) rd(8'(a), 8'h00, "reset value");
    rd(8'h40, 8'h00, "unmapped");
    wr(8'h54, 8'hFF);
    rd(8'h54, 8'h0F, "monitor bits");
    wr(8'h56, 8'hFF);
    rd(8'h56, 8'h00, "status write");
    wr(8'h54, 8'h01);
    $display("reset test done");
  endtask
  task automatic t_pin;
    wr(8'h50, 8'h03);
    wr(8'h60, 8'h0F);
    wr(8'h68, 8'h05);
    wr(8'h6A, 8'h05);
    wr(8'h55, 8'h01);
    idle(6);
    chk("no match", 4'h0, active);
    pinIn <= 16'h0008;
    idle(6);
    chk("match", 4'h1, active);
    chk("irq masked", 1'b0, irq);
    chk("pin value", {normOut[15:4], 4'h5}, pinOut);
    chk("pin enable", {normEnN[15:4], 4'hA}, pinEnN);
    rd(8'h57, 8'h01, "flag set");
    pinIn <= 16'h0000;
    idle(6);
    chk("held", 4'h1, active);
    wr(8'h58, 8'h01);
    idle(1);
    chk("irq on", 1'b1, irq);
    wr(8'h57, 8'h01);
    idle(1);
    chk("irq off", 1'b0, irq);
    wr(8'h55, 8'h00);
    idle(2);
    chk("disabled", 4'h0, active);
    chk("pins back", normOut, pinOut);
    chk("enables back", normEnN, pinEnN);
    $display("pin test done");
  endtask
  task automatic t_cmp;
    logic [5:0] base;
    for (int i = 0; i < 7; i++) begin
      base = i[0] ? 6'h00 : 6'h3F;
      wr(8'h55, 8'h00);
      wr(8'h54, {6'h00, i[0], 1'b0});
      wr(8'h51, i == 0 ? 8'h10 : i == 6 ? 8'h12 : {i == 5 ? 3'h7 : 3'(i - 1), 5'h11});
      cmpIn[5:0] <= base;
      wr(8'h55, 8'h02);
      idle(6);
      chk("idle source", 4'h0, active);
      cmpIn[5:0] <= (i < 6) ? base ^ (6'h01 << i) : ~base;
      idle(6);
      chk("source match", i < 6 ? 4'h2 : 4'h0, active);
    end
    $display("source test done");
  endtask
  // functions 2 and 3 on high pins, one pin claimed by both
  task automatic t_share;
    wr(8'h55, 8'h00);
    wr(8'h57, 8'h0F);
    wr(8'h52, 8'h02);
    wr(8'h53, 8'h0F);
    wr(8'h54, 8'h04);
    wr(8'h65, 8'h42);
    wr(8'h67, 8'h02);
    wr(8'h69, 8'h42);
    wr(8'h6B, 8'h02);
    wr(8'h58, 8'h08);
    wr(8'h55, 8'h04);
    idle(6);
    chk("shared idle", 4'h0, active);
    cmpIn[6] <= 1'b1;
    idle(6);
    chk("comparator two", 4'h4, active);
    chk("irq gated", 1'b0, irq);
    chk("high pin value", normOut | 16'h4200, pinOut);
    chk("high pin enable", (normEnN | 16'h4000) & ~16'h0200, pinEnN);
    wr(8'h55, 8'h0C);
    idle(4);
    chk("both active", 4'hC, active);
    chk("irq enabled flag", 1'b1, irq);
    rd(8'h57, 8'h0C, "two flags");
    wr(8'h55, 8'h08);
    idle(2);
    chk("one disabled", 4'h8, active);
    chk("shared pin value", normOut | 16'h0200, pinOut);
    chk("shared pin enable", normEnN & ~16'h0200, pinEnN);
    wr(8'h57, 8'h08);
    idle(1);
    chk("flag stays clear", 1'b0, irq);
    wr(8'h55, 8'h00);
    cmpIn[6] <= 1'b0;
    $display("share test done");
  endtask
  initial begin
    {regWrite, regRead, regAddr, regWdata} = '0;
    {pinIn, cmpIn} = '0;
    normOut = 16'hA5C3;
    normEnN = 16'h0FF0;
    resetn = 1'b0;
    repeat (2) @(posedge sys_clk);
    resetn <= 1'b1;
    t_reset();
    t_pin();
    t_cmp();
    t_share();
    summarize();
  end
endmodule
`default_nettype wire
